/* File: tiv_pkg.sv */
package tiv_pkg;
    // trap vectors; octal address beside each
    localparam logic [15:0] VEC_ERR        = 16'h0004; // 4
    localparam logic [15:0] VEC_PARITY     = 16'h004C; // 114
    localparam logic [15:0] VEC_TRACE      = 16'h000C; // 14
    localparam logic [15:0] VEC_EMU_TRAP   = 16'h0018; // 30
    localparam logic [15:0] VEC_IO_TRAP    = 16'h0010; // 20
    localparam logic [15:0] VEC_BREAK      = 16'h000C; // 14
    localparam logic [15:0] VEC_SUPER_CALL = 16'h0008; // 10
    localparam logic [15:0] VEC_SWREQ      = 16'h00A0; // 240
    localparam logic [15:0] VEC_LCLK       = 16'h0040; // 100
    localparam logic [2:0]  LCLK_LEVEL  = 3'h6;
    // register offsets (byte addresses)
    localparam logic [3:0]  OFS_SWREQ   = 4'h0;
    localparam logic [3:0]  OFS_LCLK    = 4'h4;
    localparam logic [3:0]  OFS_STAT    = 4'h8;
    localparam logic [3:0]  OFS_MASK    = 4'hC;
    // field positions
    localparam int SWREQ_LO   = 9;
    localparam int SWREQ_ENC  = 5;
    localparam int SWREQ_ENC2 = 1;
    localparam int LCLK_EN    = 6;
    localparam int TRACE_BIT  = 4;
    localparam int ERR_RED    = 2;
    localparam int ERR_YEL    = 3;
    localparam int ERR_TMO    = 4;
    localparam int ERR_NXM    = 5;
    localparam int ERR_ADR    = 6;
    localparam int ERR_HALT   = 7;
    // status bits: 0 trap taken, 1 console entry
    localparam int ST_TRAP    = 0;
    localparam int ST_CONS    = 1;
    localparam logic [15:0] RST_16 = 16'h0000;
    localparam logic [1:0]  RST_2  = 2'h0;
    typedef enum logic [1:0] {
        TIV_NONE, TIV_TRAP, TIV_CONS
    } tiv_kind_t;
    typedef enum {TIV_IDLE, TIV_VREAD} tiv_state_t;
    // highest set level among software request bits 15:9 (bit 15 and 14 give 7)
    function automatic logic [2:0] tiv_sw_level(input logic [6:0] r);
        logic [2:0] l;
        l = 3'h0;
        for (int i = 0; i < 7; i++) begin
            if (r[i]) begin
                l = (i >= 5) ? 3'h7 : 3'(i + 1);
            end
        end
        return l;
    endfunction
endpackage

/* File: tiv_grant_if.sv */
`timescale 1ns/1ps
interface tiv_grant_if;
    logic       take;
    tiv_pkg::tiv_kind_t kind;
    logic [15:0] vector;
    logic [2:0]  level;
    logic        err_halt;
    modport arb  (output take, kind, vector, level, err_halt);
    modport top  (input take, kind, vector, level, err_halt);
endinterface

/* File: tiv_arb.sv */
`timescale 1ns/1ps
module tiv_arb
    import tiv_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  err_bits,
    input  wire logic        parity_abort,
    input  wire logic        trace_en,
    input  wire logic        emu_i,
    input  wire logic        io_i,
    input  wire logic        brk_i,
    input  wire logic        sup_i,
    input  wire logic        halt_instr,
    input  wire logic        kernel_mode,
    input  wire logic        jumper_in,
    input  wire logic [3:0]  irq,
    input  wire logic [15:0] irq_vec,
    input  wire logic        lclk_req,
    input  wire logic [2:0]  sw_lvl,
    input  wire logic [2:0]  cur_pri,
    input  wire logic        halt_line,
    input  wire logic        vec_read,
    input  wire logic        busy,
    tiv_grant_if.arb         g
);
    logic       nm_err;
    logic       take_d;
    tiv_kind_t  kind_d;
    logic [15:0] vec_d;
    logic [2:0] lvl_d;
    logic       eh_d;
    logic [2:0] irq_lvl;
    logic       irq_any;

    assign nm_err = err_bits[ERR_RED] | err_bits[ERR_YEL] | err_bits[ERR_ADR]
                  | err_bits[ERR_TMO] | err_bits[ERR_NXM];

    always_comb begin
        irq_any = 1'b0;
        irq_lvl = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (irq[i]) begin
                irq_any = 1'b1;
                irq_lvl = 3'(i + 4);
            end
        end
    end

    always_comb begin
        take_d = 1'b1;
        kind_d = TIV_TRAP;
        vec_d  = RST_16;
        lvl_d  = 3'h0;
        eh_d   = 1'b0;
        if (halt_line && vec_read) begin
            kind_d = TIV_CONS;
        end else if (nm_err) begin
            vec_d = VEC_ERR;
        end else if (parity_abort) begin
            vec_d = VEC_PARITY;
        end else if (halt_instr && kernel_mode) begin
            if (jumper_in) begin
                kind_d = TIV_CONS;
            end else begin
                vec_d = VEC_ERR;
            end
        end else if (halt_instr) begin
            vec_d = VEC_ERR;
            eh_d  = 1'b1;
        end else if (emu_i) begin
            vec_d = VEC_EMU_TRAP;
        end else if (io_i) begin
            vec_d = VEC_IO_TRAP;
        end else if (brk_i) begin
            vec_d = VEC_BREAK;
        end else if (sup_i) begin
            vec_d = VEC_SUPER_CALL;
        end else if (trace_en) begin
            vec_d = VEC_TRACE;
        // maskable above priority; same level: software first, then clock, then bus
        end else if (sw_lvl > cur_pri && sw_lvl >= irq_lvl
                     && !(lclk_req && LCLK_LEVEL > sw_lvl)) begin
            vec_d = VEC_SWREQ;
            lvl_d = sw_lvl;
        end else if (lclk_req && LCLK_LEVEL > cur_pri && LCLK_LEVEL >= irq_lvl) begin
            vec_d = VEC_LCLK;
            lvl_d = LCLK_LEVEL;
        end else if (irq_any && irq_lvl > cur_pri) begin
            vec_d = irq_vec;
            lvl_d = irq_lvl;
        end else if (halt_line) begin
            kind_d = TIV_CONS;
        end else begin
            take_d = 1'b0;
            kind_d = TIV_NONE;
        end
        if (busy) begin
            take_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            g.take     <= 1'b0;
            g.kind     <= TIV_NONE;
            g.vector   <= RST_16;
            g.level    <= 3'h0;
            g.err_halt <= 1'b0;
        end else begin
            g.take     <= take_d;
            g.kind     <= take_d ? kind_d : TIV_NONE;
            g.vector   <= vec_d;
            g.level    <= lvl_d;
            g.err_halt <= take_d & eh_d;
        end
    end

    property p_trap_vec;
        @(posedge ref_clk) disable iff (sys_rst)
        (!busy && !(halt_line && vec_read) && nm_err) |=> (g.take && g.vector == VEC_ERR);
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("error trap not via 4");

    property p_parity;
        @(posedge ref_clk) disable iff (sys_rst)
        (!busy && !vec_read && !nm_err && parity_abort) |=> (g.vector == VEC_PARITY);
    endproperty
    a_parity: assert property (p_parity) else $error("parity trap vector wrong");

    property p_halt_vread;
        @(posedge ref_clk) disable iff (sys_rst)
        (!busy && halt_line && vec_read) |=> (g.take && g.kind == TIV_CONS);
    endproperty
    a_halt_vread: assert property (p_halt_vread) else $error("halt lost in vector read");

    property p_illegal_halt;
        @(posedge ref_clk) disable iff (sys_rst)
        g.err_halt |-> (g.vector == VEC_ERR && g.kind == TIV_TRAP);
    endproperty
    a_illegal_halt: assert property (p_illegal_halt) else $error("illegal halt wrong");

    property p_mask_level;
        @(posedge ref_clk) disable iff (sys_rst)
        (g.take && g.level != 3'h0) |-> (g.level > $past(cur_pri));
    endproperty
    a_mask_level: assert property (p_mask_level) else $error("maskable at low level");

    property p_emu_trap;
        @(posedge ref_clk) disable iff (sys_rst)
        (!busy && !vec_read && !nm_err && !parity_abort && !halt_instr && emu_i)
            |=> (g.vector == VEC_EMU_TRAP);
    endproperty
    a_emu_trap: assert property (p_emu_trap) else $error("emulator trap vector wrong");

    property p_lclk;
        @(posedge ref_clk) disable iff (sys_rst)
        (g.take && g.vector == VEC_LCLK && g.level == LCLK_LEVEL) |-> $past(lclk_req);
    endproperty
    a_lclk: assert property (p_lclk) else $error("clock irq without request");

    property p_busy;
        @(posedge ref_clk) disable iff (sys_rst)
        busy |=> !g.take;
    endproperty
    a_busy: assert property (p_busy) else $error("grant while busy");
endmodule

/* File: tiv_top.sv */
`timescale 1ns/1ps
// What this block does
// - four bus request lines, levels 4 to 7, vector supplied by requester
// - seven software request bits 15:9 giving levels 1 to 5 and 7, vector 240, bits 15 and 14 level 7
// - stack, address and timeout errors trap through vector 4
// - parity or abort input traps through vector 114
// - trace flag bit 4 of status word traps through vector 14
// - emulator trap instruction traps through vector 30
// - io trap instruction traps through vector 20
// - breakpoint instruction traps through vector 14
// - supervisor call instruction traps through vector 10
// - halt line enters console debugger, no vector fetched
// - halt line lowest priority except highest during vector read
// - kernel halt: jumper in enters console, removed traps through 4
// - non-kernel halt traps through 4 and sets error bit 7
// - line clock event with enable bit gives level 6 through 100
// - software register bits 7:5 read highest pending level
module tiv_top
    import tiv_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq_out,
    // pins
    input  wire logic [3:0]  irq_pin,
    input  wire logic [15:0] irq_vec,
    input  wire logic        line_clock_event,
    input  wire logic        parity_abort_pin,
    input  wire logic        halt_pin,
    input  wire logic        halt_option_jumper,
    // processor core, same clock
    input  wire logic [7:0]  err_bits,
    input  wire logic [15:0] processor_status_word,
    input  wire logic        emulator_trap_instruction,
    input  wire logic        io_trap_instruction,
    input  wire logic        breakpoint_trap_instruction,
    input  wire logic        call_supervisor_instruction,
    input  wire logic        halt_instruction,
    input  wire logic        vec_read,
    input  wire logic        trap_done,
    output logic             trap_req,
    output logic [15:0]      trap_vector,
    output logic             console_debugger_mode,
    output logic             emergency_stack,
    output logic             err_illegal_halt
);
    tiv_grant_if g ();

    logic [23:0] sync1_q;
    logic [23:0] sync2_q;
    logic [15:0] software_interrupt_request_register_q;
    logic        lclk_en_q;
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic        busy_q;
    logic        rd_pend_q;
    logic [2:0]  software_request_level;
    logic        kernel;
    logic        wr_stat;
    logic [1:0]  ev;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: irq[3:0], clock event, parity, halt, jumper, vector 23:8
    // the vector word is held by its requester while the line is up, so it
    // settles in step with the synchronised request line
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 24'h000000;
            sync2_q <= 24'h000000;
        end else begin
            sync1_q <= {irq_vec, halt_option_jumper, halt_pin, parity_abort_pin,
                        line_clock_event, irq_pin};
            sync2_q <= sync1_q;
        end
    end

    assign software_request_level = tiv_sw_level(software_interrupt_request_register_q[15:9]);
    // mode field in status word bits 15:14, zero is kernel
    assign kernel = processor_status_word[15:14] == 2'h0;

    tiv_arb u_arb (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .err_bits     (err_bits),
        .parity_abort (sync2_q[5]),
        .trace_en     (processor_status_word[TRACE_BIT]),
        .emu_i        (emulator_trap_instruction),
        .io_i         (io_trap_instruction),
        .brk_i        (breakpoint_trap_instruction),
        .sup_i        (call_supervisor_instruction),
        .halt_instr   (halt_instruction),
        .kernel_mode  (kernel),
        .jumper_in    (sync2_q[7]),
        .irq          (sync2_q[3:0]),
        .irq_vec      (sync2_q[23:8]),
        .lclk_req     (sync2_q[4] & lclk_en_q),
        .sw_lvl       (software_request_level),
        .cur_pri      (processor_status_word[7:5]),
        .halt_line    (sync2_q[6]),
        .vec_read     (vec_read),
        .busy         (busy_q | g.take),
        .g            (g.arb)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // grant outputs; held until the core acknowledges, so one event per service
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q                <= 1'b0;
            trap_req              <= 1'b0;
            trap_vector           <= RST_16;
            console_debugger_mode <= 1'b0;
            emergency_stack       <= 1'b0;
            err_illegal_halt      <= 1'b0;
        end else if (g.take) begin
            busy_q                <= 1'b1;
            trap_req              <= g.kind == TIV_TRAP;
            console_debugger_mode <= g.kind == TIV_CONS;
            trap_vector           <= g.vector;
            // emergency stack on kernel halt without jumper
            emergency_stack       <= halt_instruction & kernel & ~sync2_q[7]
                                     & (g.vector == VEC_ERR) & ~g.err_halt;
            err_illegal_halt      <= g.err_halt;
        end else if (trap_done) begin
            busy_q                <= 1'b0;
            trap_req              <= 1'b0;
            console_debugger_mode <= 1'b0;
            emergency_stack       <= 1'b0;
            err_illegal_halt      <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register writes
    // software request bits, only request bits 15:9 stored, bits 8:0 zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            software_interrupt_request_register_q <= RST_16;
        end else if (avs_write && !avs_waitrequest && avs_address == OFS_SWREQ) begin
            software_interrupt_request_register_q <= {avs_writedata[15:9], 9'h000};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lclk_en_q <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_address == OFS_LCLK) begin
            lclk_en_q <= avs_writedata[LCLK_EN];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= RST_2;
        end else if (avs_write && !avs_waitrequest && avs_address == OFS_MASK) begin
            mask_q <= avs_writedata[1:0];
        end
    end

    // sticky status; new event beats the write-one clear
    assign wr_stat = avs_write && !avs_waitrequest && avs_address == OFS_STAT;
    assign ev[ST_TRAP] = g.take && g.kind == TIV_TRAP;
    assign ev[ST_CONS] = g.take && g.kind == TIV_CONS;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= RST_2;
        end else begin
            stat_q <= (stat_q & ~(wr_stat ? avs_writedata[1:0] : 2'h0)) | ev;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus answer: one wait cycle on every access, data registered
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_q       <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            rd_pend_q       <= (avs_read | avs_write) & avs_waitrequest & ~rd_pend_q;
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest & ~rd_pend_q);
            if (avs_read) begin
                unique case (avs_address)
                    // encoded level in 7:5 and 3:1
                    OFS_SWREQ: avs_readdata <= {16'h0000,
                        software_interrupt_request_register_q[15:9], 1'b0,
                        software_request_level, 1'b0, software_request_level, 1'b0};
                    OFS_LCLK:  avs_readdata <= {25'h0, lclk_en_q, 6'h00};
                    OFS_STAT:  avs_readdata <= {30'h0, stat_q};
                    OFS_MASK:  avs_readdata <= {30'h0, mask_q};
                    default:   avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    property p_sw_vec;
        @(posedge ref_clk) disable iff (sys_rst)
        (g.take && g.vector == VEC_SWREQ && g.level != 3'h0)
            |-> (g.level == $past(software_request_level));
    endproperty
    a_sw_vec: assert property (p_sw_vec) else $error("software level mismatch");

    property p_cons;
        @(posedge ref_clk) disable iff (sys_rst)
        (g.take && g.kind == TIV_CONS) |=> (console_debugger_mode && !trap_req);
    endproperty
    a_cons: assert property (p_cons) else $error("console entry wrong");

    property p_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        (trap_req && !trap_done) |=> trap_req;
    endproperty
    a_hold: assert property (p_hold) else $error("trap request dropped early");

    property p_estk;
        @(posedge ref_clk) disable iff (sys_rst)
        emergency_stack |-> (trap_req && trap_vector == VEC_ERR);
    endproperty
    a_estk: assert property (p_estk) else $error("emergency stack without trap");

    property p_ill_halt;
        @(posedge ref_clk) disable iff (sys_rst)
        err_illegal_halt |-> (trap_req && trap_vector == VEC_ERR && !console_debugger_mode);
    endproperty
    a_ill_halt: assert property (p_ill_halt) else $error("illegal halt flag wrong");

    property p_stat_set;
        @(posedge ref_clk) disable iff (sys_rst)
        (|ev) |=> ((stat_q & $past(ev)) == $past(ev));
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("status event lost");

    property p_irq_on;
        @(posedge ref_clk) disable iff (sys_rst)
        (|(stat_q & mask_q)) |=> irq_out;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("interrupt output missing");

    property p_irq_off;
        @(posedge ref_clk) disable iff (sys_rst)
        !(|(stat_q & mask_q)) |=> !irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt output spurious");

    property p_bus_ans;
        @(posedge ref_clk) disable iff (sys_rst)
        ((avs_read || avs_write) && avs_waitrequest && !rd_pend_q) |=> !avs_waitrequest;
    endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");

    property p_bus_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("waitrequest low while idle");
endmodule

/* File: tiv_dev_model.sv */
`timescale 1ns/1ps
// bus peripherals: one requester per line, each answering with its own vector
module tiv_dev_model #(
    parameter logic [15:0] BASE = 16'h0180
) (
    input  wire logic        ref_clk,
    input  wire logic [3:0]  raise,
    output logic      [3:0]  irq_pin = 4'h0,
    output logic      [15:0] irq_vec = 16'h0
);
    ////////////////////////////////////////////////////////////////////////////////
    // requester supplies vector
    // vector of the highest raised line is held while that line stays up;
    // a released vector bus keeps changing so a stale value is never taken
    always_ff @(posedge ref_clk) begin
        irq_pin <= raise;
        if (raise == 4'h0) begin
            irq_vec <= ~irq_vec;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (raise[i]) begin
                    irq_vec <= BASE + 16'(i * 4);
                end
            end
        end
    end
endmodule

/* File: trap_interrupt_vectoring_test.sv */
`timescale 1ns/1ps
module trap_interrupt_vectoring_test;
    import tiv_pkg::*;
    localparam logic [15:0] DEV_BASE = 16'h0180;
    logic        ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq_out;
    logic [3:0]  avs_address, raise, irq_pin;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [15:0] irq_vec, cstat, trap_vector;
    logic        lce, par, hpin, jmp, vrd, tdone, trap_req, cons, estk, ill;
    logic [7:0]  errb;
    logic [4:0]  ins;
    int          err_count, num_checks, cyc;
    logic [15:0] ivec [4] = '{VEC_EMU_TRAP, VEC_IO_TRAP, VEC_BREAK, VEC_SUPER_CALL};
    logic [3:0]  ofs [5]  = '{OFS_SWREQ, OFS_LCLK, OFS_STAT, OFS_MASK, 4'h2};
    ////////////////////////////////////////////////////////////////////////////////
    tiv_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_out(irq_out),
        .irq_pin(irq_pin), .irq_vec(irq_vec), .line_clock_event(lce),
        .parity_abort_pin(par), .halt_pin(hpin), .halt_option_jumper(jmp),
        .err_bits(errb), .processor_status_word(cstat), .emulator_trap_instruction(ins[0]),
        .io_trap_instruction(ins[1]), .breakpoint_trap_instruction(ins[2]),
        .call_supervisor_instruction(ins[3]), .halt_instruction(ins[4]),
        .vec_read(vrd), .trap_done(tdone), .trap_req(trap_req), .trap_vector(trap_vector),
        .console_debugger_mode(cons), .emergency_stack(estk), .err_illegal_halt(ill));
    tiv_dev_model #(.BASE(DEV_BASE)) dev_u (.ref_clk(ref_clk), .raise(raise),
        .irq_pin(irq_pin), .irq_vec(irq_vec));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one access; read data lands in rd at the completing edge; a hang ends at the timeout
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    // st = {trap_req, console, emergency stack, illegal halt}
    task automatic expect_ev(input logic [3:0] st, input logic [15:0] v);
        int n;
        n = 0;
        while (!(trap_req === 1'b1 || cons === 1'b1) && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        chk({12'h0, trap_req, cons, estk, ill, (st[3] ? trap_vector : 16'h0)}, {12'h0, st, v});
    endtask
    task automatic expect_none();
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(posedge ref_clk);
            seen = seen | trap_req | cons;
        end
        chk({31'h0, seen}, 32'h0);
    endtask
    // causes are dropped before the service pulse so nothing is granted twice
    task automatic done();
        ins <= 5'h0;
        errb <= 8'h0;
        {par, hpin, lce, vrd} <= 4'h0;
        raise <= 4'h0;
        repeat (6) @(posedge ref_clk);
        tdone <= 1'b1;
        @(posedge ref_clk);
        tdone <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge ref_clk);
            cyc++;
            if (cyc == 6000) begin
                err_count++;
                end_of_test();
            end
        end
    end
    initial begin
        {sys_rst, jmp} = 2'h3;
        {avs_read, avs_write, lce, par, hpin, vrd, tdone} = 7'h0;
        {avs_address, raise, ins, errb} = 21'h0;
        avs_writedata = 32'h0;
        cstat = 16'h0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, ofs[i], 32'h0);
            chk(rd, 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            ins[i] <= 1'b1;
            expect_ev(4'h8, ivec[i]);
            done();
        end
        cstat <= 16'h0010;
        expect_ev(4'h8, VEC_TRACE);
        cstat <= 16'h0;
        done();
        for (int i = 2; i < 7; i++) begin
            errb <= 8'(1 << i);
            expect_ev(4'h8, VEC_ERR);
            done();
        end
        // non-maskable beats instruction, instruction beats bus request;
        // the unsynchronised cause is raised late so both meet on one edge
        par <= 1'b1;
        repeat (2) @(posedge ref_clk);
        ins[0] <= 1'b1;
        expect_ev(4'h8, VEC_PARITY);
        done();
        raise <= 4'h8;
        repeat (3) @(posedge ref_clk);
        ins[0] <= 1'b1;
        expect_ev(4'h8, VEC_EMU_TRAP);
        done();
        ins[4] <= 1'b1;
        expect_ev(4'h4, 16'h0);
        // the jumper is synchronised, so it moves while nothing is pending
        jmp <= 1'b0;
        done();
        ins[4] <= 1'b1;
        expect_ev(4'hA, VEC_ERR);
        done();
        {cstat, jmp} <= {16'hC000, 1'b1};
        ins[4] <= 1'b1;
        expect_ev(4'h9, VEC_ERR);
        cstat <= 16'h0;
        done();
        hpin <= 1'b1;
        expect_ev(4'h4, 16'h0);
        done();
        {hpin, par} <= 2'h3;
        expect_ev(4'h8, VEC_PARITY);
        done();
        {vrd, hpin, par} <= 3'h7;
        expect_ev(4'h4, 16'h0);
        done();
        for (int b = 9; b < 16; b++) begin
            acc(1'b1, OFS_SWREQ, 32'(1 << b));
            acc(1'b0, OFS_SWREQ, 32'h0);
            chk(rd, 32'(1 << b) | 32'(((b > 13) ? 7 : b - 8) * 34));
        end
        // the first write above was granted; priority goes up before the
        // service pulse so the level 7 request left behind is not taken again
        cstat <= 16'h00E0;
        done();
        acc(1'b1, OFS_SWREQ, 32'h2000);
        expect_none();
        cstat <= 16'h0080;
        expect_ev(4'h8, VEC_SWREQ);
        acc(1'b1, OFS_SWREQ, 32'h0);
        cstat <= 16'h0;
        done();
        lce <= 1'b1;
        expect_none();
        acc(1'b1, OFS_LCLK, 32'h40);
        acc(1'b0, OFS_LCLK, 32'h0);
        chk(rd, 32'h40);
        expect_ev(4'h8, VEC_LCLK);
        acc(1'b1, OFS_LCLK, 32'h0);
        done();
        {cstat, raise} <= {16'h0080, 4'h1};
        expect_none();
        cstat <= 16'h0060;
        expect_ev(4'h8, DEV_BASE);
        done();
        {cstat, raise} <= {16'h0, 4'h9};
        expect_ev(4'h8, DEV_BASE + 16'hC);
        done();
        // sticky status, mask and the level output
        acc(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h3);
        chk({31'h0, irq_out}, 32'h0);
        acc(1'b1, OFS_MASK, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq_out}, 32'h1);
        acc(1'b1, OFS_STAT, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq_out}, 32'h0);
        acc(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h2);
        end_of_test();
    end
endmodule
